// ---- design/lcsc_pkg.sv ----
// constants and types for the led channel select register bank
package lcsc_pkg;
  localparam logic [7:0] OFS_DIM_DEBUG  = 8'h0d;
  localparam logic [7:0] OFS_SEL_INPUT  = 8'h0e;
  localparam logic [7:0] OFS_SAMPLE     = 8'h0f;
  localparam logic [7:0] OFS_CUR_LOW    = 8'h13;
  localparam logic [7:0] OFS_CUR_HI0    = 8'h14;
  localparam logic [7:0] OFS_CUR_HI1    = 8'h15;
  localparam logic [7:0] OFS_CUR_HI2    = 8'h16;
  localparam logic [7:0] OFS_RESERVED   = 8'h17;
  localparam logic [7:0] OFS_OVERHEAT   = 8'h18;
  localparam logic [7:0] OFS_HEADROOM01 = 8'h19;
  localparam logic [7:0] OFS_HEADROOM2  = 8'h1a;
  localparam logic [7:0] OFS_CONVERTER  = 8'h1b;
  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_SEL_INPUT  = 8'h24;
  localparam logic [7:0] RST_OVERHEAT   = 8'he4;
  // field positions and codes
  localparam int BIT_VMID_FORCE   = 7;
  localparam int BIT_CONV_FORCE   = 6;
  localparam int BIT_DIM_INVERT   = 2;
  localparam int BIT_ILLEGAL_HOLD = 1;
  localparam int BIT_PERIOD_FREE  = 0;
  localparam int BIT_DIM_OFF      = 7;
  localparam int BIT_POL_FLIP     = 6;
  localparam int BIT_SAMPLE_FREE  = 1;
  localparam int BIT_SAMPLE_OFF   = 0;
  localparam int BIT_CONV_ON      = 0;
  localparam logic [1:0] ROUTE_DIRECT = 2'h3;
  localparam logic [7:0] DIM_ILLEGAL  = 8'hff;
  // headroom step in millivolts
  localparam int HEADROOM_STEP_MV = 10;
  localparam logic [15:0] PERIOD_MAX  = 16'hffff;
  typedef enum logic [1:0] {
    LCSC_MEAS_IDLE = 2'b00,
    LCSC_MEAS_WAIT = 2'b01,
    LCSC_MEAS_RUN  = 2'b10,
    LCSC_MEAS_DONE = 2'b11
  } lcsc_meas_t;
endpackage

// ---- design/lcsc_top.sv ----
// register bank and channel routing for three led driver channels
`timescale 1ns/1ps
module lcsc_top #(
  parameter int PERIOD_W = 16
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  input  wire logic                 colour_select_pin0,
  input  wire logic                 colour_select_pin1,
  input  wire logic                 dim_pin,
  input  wire logic                 vmid_rdy_in,
  input  wire logic                 conv_rdy_in,
  input  wire logic [7:0]           temperature,
  output logic                      vmid_rdy,
  output logic                      conv_rdy,
  output logic                      out_channel_0,
  output logic                      out_channel_1,
  output logic                      out_channel_2,
  output logic                      dimming_active,
  output logic      [7:0]           dim_value,
  output logic                      sample_request,
  output logic                      overheat,
  output logic      [9:0]           current_code_0,
  output logic      [9:0]           current_code_1,
  output logic      [9:0]           current_code_2,
  output logic      [3:0]           driver_margin_set_0,
  output logic      [3:0]           driver_margin_set_1,
  output logic      [3:0]           driver_margin_set_2
);
  import lcsc_pkg::*;

  logic [7:0] dim_debug_r, sel_input_r, sample_r, cur_low_r;
  logic [7:0] cur_hi0_r, cur_hi1_r, cur_hi2_r, overheat_r, head01_r, head2_r, conv_r;
  logic [2:0] sync1_r, sync2_r, held_r;
  logic       direct_mode, dim_enable, dim_in, sel0, sel1, pwm_s;
  logic [2:0] chan_nxt;
  lcsc_meas_t meas_r;
  logic [PERIOD_W-1:0] per_cnt_r;
  logic       dim_prev_r;

  // one-hot channel from a two-bit route code
  function automatic logic [2:0] route_to_chan(input logic [1:0] code);
    case (code)
      2'h0:    route_to_chan = 3'h1;
      2'h1:    route_to_chan = 3'h2;
      2'h2:    route_to_chan = 3'h4;
      default: route_to_chan = 3'h0;
    endcase
  endfunction

  // register writes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dim_debug_r <= RST_ZERO;
      sel_input_r <= RST_SEL_INPUT;
      sample_r    <= RST_ZERO;
      cur_low_r   <= RST_ZERO;
      cur_hi0_r   <= RST_ZERO;
      cur_hi1_r   <= RST_ZERO;
      cur_hi2_r   <= RST_ZERO;
      overheat_r  <= RST_OVERHEAT;
      head01_r    <= RST_ZERO;
      head2_r     <= RST_ZERO;
      conv_r      <= RST_ZERO;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_DIM_DEBUG:  dim_debug_r <= reg_wdata;
        OFS_SEL_INPUT:  sel_input_r <= reg_wdata;
        OFS_SAMPLE:     sample_r    <= reg_wdata;
        OFS_CUR_LOW:    cur_low_r   <= reg_wdata;
        OFS_CUR_HI0:    cur_hi0_r   <= reg_wdata;
        OFS_CUR_HI1:    cur_hi1_r   <= reg_wdata;
        OFS_CUR_HI2:    cur_hi2_r   <= reg_wdata;
        OFS_OVERHEAT:   overheat_r  <= reg_wdata;
        OFS_HEADROOM01: head01_r    <= reg_wdata;
        OFS_HEADROOM2:  head2_r     <= reg_wdata;
        OFS_CONVERTER:  conv_r      <= reg_wdata;
        default:        ;
      endcase
    end
  end

  // register reads, reserved slot and unmapped read zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata <= RST_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_DIM_DEBUG:  reg_rdata <= dim_debug_r;
        OFS_SEL_INPUT:  reg_rdata <= sel_input_r;
        OFS_SAMPLE:     reg_rdata <= sample_r;
        OFS_CUR_LOW:    reg_rdata <= cur_low_r;
        OFS_CUR_HI0:    reg_rdata <= cur_hi0_r;
        OFS_CUR_HI1:    reg_rdata <= cur_hi1_r;
        OFS_CUR_HI2:    reg_rdata <= cur_hi2_r;
        OFS_OVERHEAT:   reg_rdata <= overheat_r;
        OFS_HEADROOM01: reg_rdata <= head01_r;
        OFS_HEADROOM2:  reg_rdata <= head2_r;
        OFS_CONVERTER:  reg_rdata <= conv_r;
        default:        reg_rdata <= RST_ZERO;
      endcase
    end
  end

  // pin synchronisers, first stage read only by second
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else
    begin
      sync1_r <= {dim_pin, colour_select_pin1, colour_select_pin0};
      sync2_r <= sync1_r;
    end
  end

  // inputs frozen while converter off
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      held_r <= 3'h0;
    else if (conv_r[BIT_CONV_ON])
      held_r <= sync2_r ^ {3{sel_input_r[BIT_POL_FLIP]}};
  end

  // routing decode
  always_comb
  begin
    sel0 = held_r[0];
    sel1 = held_r[1];
    pwm_s = held_r[2];
    direct_mode = (sel_input_r[5:4] == ROUTE_DIRECT) || (sel_input_r[3:2] == ROUTE_DIRECT)
                  || (sel_input_r[1:0] == ROUTE_DIRECT);
    dim_enable = !sel_input_r[BIT_DIM_OFF] && !direct_mode;
    dim_in = pwm_s ^ dim_debug_r[BIT_DIM_INVERT];
    if (direct_mode)
      chan_nxt = {pwm_s, sel1, sel0};
    else
    begin
      case ({sel1, sel0})
        2'b11:   chan_nxt = route_to_chan(sel_input_r[5:4]);
        2'b10:   chan_nxt = route_to_chan(sel_input_r[3:2]);
        2'b01:   chan_nxt = route_to_chan(sel_input_r[1:0]);
        default: chan_nxt = 3'h0;
      endcase
    end
  end

  // channel outputs and status
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      {out_channel_2, out_channel_1, out_channel_0} <= 3'h0;
      dimming_active <= 1'b0;
      vmid_rdy       <= 1'b0;
      conv_rdy       <= 1'b0;
      sample_request <= 1'b0;
      overheat       <= 1'b0;
    end
    else
    begin
      {out_channel_2, out_channel_1, out_channel_0} <= chan_nxt;
      dimming_active <= dim_enable;
      vmid_rdy       <= vmid_rdy_in || dim_debug_r[BIT_VMID_FORCE];
      conv_rdy       <= conv_rdy_in || dim_debug_r[BIT_CONV_FORCE];
      sample_request <= !sample_r[BIT_SAMPLE_OFF]
                        && (sample_r[BIT_SAMPLE_FREE] || (sel0 || sel1));
      overheat       <= temperature >= overheat_r;
    end
  end

  // current codes and headroom fields
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      current_code_0 <= 10'h000;
      current_code_1 <= 10'h000;
      current_code_2 <= 10'h000;
      driver_margin_set_0 <= 4'h0;
      driver_margin_set_1 <= 4'h0;
      driver_margin_set_2 <= 4'h0;
    end
    else
    begin
      current_code_0 <= {cur_hi0_r, cur_low_r[1:0]};
      current_code_1 <= {cur_hi1_r, cur_low_r[3:2]};
      current_code_2 <= {cur_hi2_r, cur_low_r[5:4]};
      driver_margin_set_0 <= head01_r[3:0];
      driver_margin_set_1 <= head01_r[7:4];
      driver_margin_set_2 <= head2_r[3:0];
    end
  end

  // dimming period measurement, rising edge to rising edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meas_r     <= LCSC_MEAS_IDLE;
      per_cnt_r  <= '0;
      dim_prev_r <= 1'b0;
      dim_value  <= RST_ZERO;
    end
    else
    begin
      dim_prev_r <= dim_in;
      case (meas_r)
        LCSC_MEAS_IDLE:
          if (dim_enable)
            meas_r <= LCSC_MEAS_WAIT;
        LCSC_MEAS_WAIT:
          if (!dim_enable)
            meas_r <= LCSC_MEAS_IDLE;
          else if (dim_in && !dim_prev_r)
          begin
            per_cnt_r <= '0;
            meas_r    <= LCSC_MEAS_RUN;
          end
        LCSC_MEAS_RUN:
          if (!dim_enable)
            meas_r <= LCSC_MEAS_IDLE;
          else if (dim_in && !dim_prev_r)
          begin
            per_cnt_r <= '0;
            if (!dim_debug_r[BIT_PERIOD_FREE])
              meas_r <= LCSC_MEAS_DONE;
          end
          else if (&per_cnt_r)
          begin
            // illegal: period overflow
            if (!dim_debug_r[BIT_ILLEGAL_HOLD])
              dim_value <= DIM_ILLEGAL;
            per_cnt_r <= '0;
          end
          else
            per_cnt_r <= per_cnt_r + 1'b1;
        LCSC_MEAS_DONE:
          if (!dim_enable)
            meas_r <= LCSC_MEAS_IDLE;
          else if (dim_debug_r[BIT_PERIOD_FREE])
            meas_r <= LCSC_MEAS_WAIT;
        default: meas_r <= LCSC_MEAS_IDLE;
      endcase
      if (meas_r == LCSC_MEAS_RUN && dim_in && !dim_prev_r)
        dim_value <= per_cnt_r[PERIOD_W-1 -: 8];
    end
  end

  // checks
  vmid_force_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(dim_debug_r[BIT_VMID_FORCE]) |-> vmid_rdy) else $error("vmid not forced");
  conv_force_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(dim_debug_r[BIT_CONV_FORCE]) |-> conv_rdy) else $error("conv not forced");
  dim_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(sel_input_r[BIT_DIM_OFF] || direct_mode) |-> !dimming_active)
    else $error("dimming not disabled");
  direct_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(direct_mode) |-> out_channel_0 == $past(held_r[0]) && out_channel_1 == $past(held_r[1])
    && out_channel_2 == $past(held_r[2])) else $error("direct map wrong");
  idle_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(!direct_mode && held_r[1:0] == 2'b00) |-> !out_channel_0 && !out_channel_1 && !out_channel_2)
    else $error("channel on at 0,0");
  conv_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !conv_r[BIT_CONV_ON] |=> $stable(held_r)) else $error("input moved while off");
  sample_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(sample_r[BIT_SAMPLE_OFF]) |-> !sample_request) else $error("sample while off");
  code_pack_a: assert property (@(posedge clk) disable iff (!reset_n)
    current_code_2 == {$past(cur_hi2_r), $past(cur_low_r[5:4])}) else $error("code pack wrong");
endmodule

// ---- testbench/lcsc_disp_model.sv ----
// display controller model driving the colour select and dimming pins
`timescale 1ns/1ps
module lcsc_disp_model (
  input  wire logic       clk,
  input  wire logic [1:0] want_sel,
  input  wire logic       want_dim,
  output logic            colour_select_pin0,
  output logic            colour_select_pin1,
  output logic            dim_pin
);
  // pins start low before the controller takes over
  initial
  begin
    colour_select_pin0 = 1'b0;
    colour_select_pin1 = 1'b0;
    dim_pin = 1'b0;
  end
  // pins follow the wanted levels by non-blocking update, free of races with the bench
  always @(posedge clk)
  begin
    colour_select_pin0 <= want_sel[0];
    colour_select_pin1 <= want_sel[1];
    dim_pin <= want_dim;
  end
endmodule

// ---- testbench/lcsc_top_tb_top.sv ----
// self-checking bench for the led channel select register bank
`timescale 1ns/1ps
module lcsc_top_tb_top;
  import lcsc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, want_dim = 1'b0;
  logic vmid_rdy_in = 1'b0, conv_rdy_in = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, temperature = 8'h00, reg_rdata, dim_value, rv, ctl, a, b;
  logic [1:0] want_sel = 2'h0;
  logic [7:0] hi [3];
  logic s0, s1, dp, vmid_rdy, conv_rdy, ch0, ch1, ch2, dimming_active, sample_request, overheat;
  logic [9:0] current_code_0, current_code_1, current_code_2;
  logic [3:0] driver_margin_set_0, driver_margin_set_1, driver_margin_set_2;
  int error_cnt = 0, check_count = 0, cyc = 0;
  logic [7:0] ofs [12] = '{8'h0d, 8'h0e, 8'h0f, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
  logic [7:0] rst [12] = '{8'h00, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he4, 8'h00, 8'h00, 8'h00};
  // sample table: pins, sampling register, expected request
  logic [1:0] smp_sel [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
  logic [7:0] smp_reg [4] = '{8'h00, 8'h02, 8'h03, 8'h00};
  logic       smp_exp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  lcsc_top #(.PERIOD_W(8)) i_lcsc_top (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .colour_select_pin0(s0), .colour_select_pin1(s1),
    .dim_pin(dp), .vmid_rdy_in(vmid_rdy_in), .conv_rdy_in(conv_rdy_in), .temperature(temperature),
    .vmid_rdy(vmid_rdy), .conv_rdy(conv_rdy), .out_channel_0(ch0), .out_channel_1(ch1), .out_channel_2(ch2),
    .dimming_active(dimming_active), .dim_value(dim_value), .sample_request(sample_request),
    .overheat(overheat), .current_code_0(current_code_0), .current_code_1(current_code_1),
    .current_code_2(current_code_2), .driver_margin_set_0(driver_margin_set_0),
    .driver_margin_set_1(driver_margin_set_1), .driver_margin_set_2(driver_margin_set_2));
  lcsc_disp_model i_lcsc_disp_model (.clk(clk), .want_sel(want_sel), .want_dim(want_dim),
    .colour_select_pin0(s0), .colour_select_pin1(s1), .dim_pin(dp));
  // 50 MHz clock
  always #10 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = ad;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // restart measurement, then rises 40 cycles apart and falls 20 apart
  task automatic dim_meas(input logic [7:0] dbg);
    want_dim = 1'b0;
    wr(OFS_DIM_DEBUG, dbg);
    wr(OFS_SEL_INPUT, 8'ha4);
    wr(OFS_SEL_INPUT, RST_SEL_INPUT);
    wait_cyc(6);
    want_dim = 1'b1;
    wait_cyc(30);
    want_dim = 1'b0;
    wait_cyc(10);
    want_dim = 1'b1;
    wait_cyc(10);
    want_dim = 1'b0;
    wait_cyc(20);
  endtask
  // any route field at 11b selects direct drive
  function automatic logic exp_direct(input logic [7:0] c);
    return c[5:4] == 2'h3 || c[3:2] == 2'h3 || c[1:0] == 2'h3;
  endfunction
  // expected channel enables from control, pin levels
  function automatic logic [2:0] exp_ch(input logic [7:0] c, input logic [1:0] sel, input logic p);
    logic [1:0] f;
    if (c[6])
    begin
      sel = ~sel;
      p = ~p;
    end
    if (exp_direct(c))
      return {p, sel[1], sel[0]};
    case (sel)
      2'h3: f = c[5:4];
      2'h2: f = c[3:2];
      2'h1: f = c[1:0];
      default: return 3'h0;
    endcase
    return 3'h1 << f;
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(82));
    wait_cyc(10);
    reset_n = 1'b1;
    wr(8'h17, 8'h5a);
    for (int i = 0; i < 12; i++)
    begin
      rd(ofs[i], rv);
      chk("reset value", rv, rst[i]);
    end
    rd(8'h30, rv);
    chk("unmapped read", rv, 8'h00);
    for (int i = 4; i < 10; i++)
    begin
      if (i == 7) continue;
      a = 8'($urandom);
      wr(ofs[i], a);
      rd(ofs[i], rv);
      chk("readback", rv, a);
    end
    // current codes from written high and low parts
    for (int i = 0; i < 3; i++)
    begin
      hi[i] = 8'($urandom);
      wr(ofs[4 + i], hi[i]);
    end
    a = 8'($urandom);
    wr(OFS_CUR_LOW, a);
    wait_cyc(2);
    chk("current 0", current_code_0, {hi[0], a[1:0]});
    chk("current 1", current_code_1, {hi[1], a[3:2]});
    chk("current 2", current_code_2, {hi[2], a[5:4]});
    b = 8'($urandom);
    wr(OFS_HEADROOM2, b);
    a = 8'($urandom);
    wr(OFS_HEADROOM01, a);
    wait_cyc(2);
    chk("margin", {driver_margin_set_2, driver_margin_set_1, driver_margin_set_0}, {b[3:0], a});
    for (int i = 0; i < 6; i++)
    begin
      a = 8'($urandom);
      temperature = (i == 0) ? a : (i == 1) ? a - 8'h01 : 8'($urandom);
      wr(OFS_OVERHEAT, a);
      wait_cyc(2);
      chk("overheat", overheat, temperature >= a);
    end
    for (int k = 0; k < 8; k++)
    begin
      {vmid_rdy_in, conv_rdy_in} = 2'($urandom);
      wr(OFS_DIM_DEBUG, {k[1:0], 6'h00});
      wait_cyc(2);
      chk("vmid ready", vmid_rdy, vmid_rdy_in | k[1]);
      chk("conv ready", conv_rdy, conv_rdy_in | k[0]);
    end
    wr(OFS_CONVERTER, 8'h01);
    for (int i = 0; i < 24; i++)
    begin
      ctl = {2'($urandom), 2'($urandom_range(2)), 2'($urandom_range(2)), 2'($urandom_range(2))};
      if (i % 4 == 3)
        ctl[2 * (i % 3) +: 2] = 2'h3; // one field routes directly
      want_sel = 2'($urandom);
      want_dim = 1'($urandom);
      wr(OFS_SEL_INPUT, ctl);
      wait_cyc(6);
      chk("channels", {ch2, ch1, ch0}, exp_ch(ctl, want_sel, want_dim));
      chk("dimming", dimming_active, !ctl[7] && !exp_direct(ctl));
    end
    wr(OFS_SEL_INPUT, 8'h27);
    wait_cyc(2);
    chk("dimming one field", dimming_active, 1'b0);
    wr(OFS_SEL_INPUT, RST_SEL_INPUT);
    want_sel = 2'h1;
    wait_cyc(6);
    wr(OFS_CONVERTER, 8'h00);
    want_sel = 2'h3;
    wait_cyc(6);
    chk("converter off", {ch2, ch1, ch0}, 3'h1);
    wr(OFS_CONVERTER, 8'h01);
    wait_cyc(6);
    chk("converter on", {ch2, ch1, ch0}, 3'h4);
    for (int i = 0; i < 4; i++)
    begin
      want_sel = smp_sel[i];
      wr(OFS_SAMPLE, smp_reg[i]);
      wait_cyc(6);
      chk("sample request", sample_request, smp_exp[i]);
    end
    // period measured once, then no further counting
    dim_meas(8'h00);
    chk("period once", dim_value, 8'h27);
    wait_cyc(260);
    chk("period not rerun", dim_value, 8'h27);
    // free running measurement overflows to the illegal code
    dim_meas(8'h01);
    chk("period free run", dim_value, 8'h27);
    wait_cyc(260);
    chk("illegal period", dim_value, DIM_ILLEGAL);
    // overflow with hold keeps the last period
    dim_meas(8'h03);
    wait_cyc(260);
    chk("illegal hold", dim_value, 8'h27);
    // inverted input measures between falling pin edges
    dim_meas(8'h04);
    chk("period inverted", dim_value, 8'h13);
    end_of_test();
  end
endmodule
